// file: core/pbs_sequencer.sv
`timescale 1ns/1ps
// Contract
// - enable inactive from power-up reset
// - off state: held low press starts power-on
// - hold is 32ms plus optional extension
// - enable active starts 512ms blanking
// - blanking ignores button; release sampled only at its end
// - release low at blanking end aborts
// - debounce button return high for 32ms
// - on state: held low press starts power-off
// - hold done: alert low, start 1024ms
// - release low during countdown drops enable
// - countdown expiry drops enable anyway
// - release low while running drops enable
// - 256ms button lockout after release shutdown
// - after turn-off, wait for new press
// - enable polarity selectable by parameter
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter int unsigned ON_TIME_EXTEND_MS = 0, // extra turn-on hold, 0 = none
  parameter int unsigned OFF_TIME_EXTEND_MS = 0, // extra turn-off hold, 0 = none
  parameter int unsigned TICK_CYC = TICK_CYCLES, // cycles per millisecond tick
  parameter bit EN_ACTIVE_HIGH = 1'b1 // enable polarity
) (
  input wire logic sys_clk_in, // 20 MHz clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic button_n_in, // pushbutton, active low
  input wire logic release_n_in, // power release from processor, active low
  output logic enable_out, // converter enable, polarity per parameter
  output logic alert_n_out, // shutdown alert, active low
  output pbs_status_s status_out // enable, alert and lockout state
);
  // hold lengths in ticks
  localparam int unsigned ON_HOLD_MS = HOLD_BASE_MS + ((ON_TIME_EXTEND_MS > 0) ?
    (HOLD_EXTRA_MS + ON_TIME_EXTEND_MS) : 0);
  localparam int unsigned OFF_HOLD_MS = HOLD_BASE_MS + ((OFF_TIME_EXTEND_MS > 0) ?
    (HOLD_EXTRA_MS + OFF_TIME_EXTEND_MS) : 0);
  localparam logic [TMR_W-1:0] ON_HOLD_T = TMR_W'(ON_HOLD_MS);
  localparam logic [TMR_W-1:0] OFF_HOLD_T = TMR_W'(OFF_HOLD_MS);
  localparam logic [TMR_W-1:0] BLANK_T = TMR_W'(BLANK_MS);
  localparam logic [TMR_W-1:0] REL_DB_T = TMR_W'(RELEASE_DB_MS);
  localparam logic [TMR_W-1:0] DOWN_T = TMR_W'(DOWN_MS);
  localparam logic [TMR_W-1:0] LOCK_T = TMR_W'(LOCKOUT_MS);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  logic button_n_s;
  logic release_n_s;
  logic tick;
  logic [TICK_W-1:0] tick_q;
  pbs_state_e state_q;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] lock_q;
  logic en_q;
  logic alert_n_q;

  pbs_sync #(.RESET_VAL(1'b1)) u_sync_button (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .async_in(button_n_in),
    .sync_out(button_n_s)
  );

  pbs_sync #(.RESET_VAL(1'b1)) u_sync_release (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .async_in(release_n_in),
    .sync_out(release_n_s)
  );

  // millisecond time base
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_q <= '0;
    end else if (tick_q == TICK_LAST) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TICK_W'(1);
    end
  end
  assign tick = (tick_q == TICK_LAST);

  // main sequence
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PBS_OFF;
      tmr_q <= '0;
      en_q <= 1'b0;
      alert_n_q <= 1'b1;
    end else begin
      unique case (state_q)
        PBS_OFF: begin
          tmr_q <= '0;
          if (!button_n_s && lock_q == '0) begin
            state_q <= PBS_ON_HOLD;
          end
        end
        PBS_ON_HOLD: begin
          if (button_n_s) begin
            state_q <= PBS_OFF;
            tmr_q <= '0;
          end else if (tmr_q == ON_HOLD_T) begin
            state_q <= PBS_BLANK;
            en_q <= 1'b1;
            tmr_q <= '0;
          end else if (tick) begin
            tmr_q <= tmr_q + TMR_W'(1);
          end
        end
        PBS_BLANK: begin
          // button not looked at here; release only sampled when tmr_q reaches BLANK_T
          if (tmr_q == BLANK_T) begin
            tmr_q <= '0;
            if (!release_n_s) begin
              en_q <= 1'b0;
              state_q <= PBS_REL_DB;
            end else begin
              state_q <= PBS_REL_DB;
            end
          end else if (tick) begin
            tmr_q <= tmr_q + TMR_W'(1);
          end
        end
        PBS_REL_DB: begin
          if (en_q && !release_n_s) begin
            en_q <= 1'b0;
            tmr_q <= '0;
          end else if (!button_n_s) begin
            tmr_q <= '0;
          end else if (tmr_q == REL_DB_T) begin
            tmr_q <= '0;
            state_q <= en_q ? PBS_RUN : PBS_OFF;
          end else if (tick) begin
            tmr_q <= tmr_q + TMR_W'(1);
          end
        end
        PBS_RUN: begin
          tmr_q <= '0;
          if (!release_n_s) begin
            en_q <= 1'b0;
            state_q <= PBS_REL_DB;
          end else if (!button_n_s) begin
            state_q <= PBS_OFF_HOLD;
          end
        end
        PBS_OFF_HOLD: begin
          if (!release_n_s) begin
            en_q <= 1'b0;
            tmr_q <= '0;
            state_q <= PBS_REL_DB;
          end else if (button_n_s) begin
            tmr_q <= '0;
            state_q <= PBS_RUN;
          end else if (tmr_q == OFF_HOLD_T) begin
            alert_n_q <= 1'b0;
            tmr_q <= '0;
            state_q <= PBS_DOWN;
          end else if (tick) begin
            tmr_q <= tmr_q + TMR_W'(1);
          end
        end
        PBS_DOWN: begin
          if (!release_n_s || tmr_q == DOWN_T) begin
            en_q <= 1'b0;
            alert_n_q <= 1'b1;
            tmr_q <= '0;
            state_q <= PBS_REL_DB;
          end else if (tick) begin
            tmr_q <= tmr_q + TMR_W'(1);
          end
        end
        default: begin
          state_q <= PBS_OFF;
          en_q <= 1'b0;
          alert_n_q <= 1'b1;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // lockout after a release-driven shutdown
  logic rel_off;
  assign rel_off = en_q && !release_n_s &&
    (state_q == PBS_RUN || state_q == PBS_OFF_HOLD || state_q == PBS_DOWN ||
     (state_q == PBS_REL_DB));

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_q <= '0;
    end else if (rel_off) begin
      lock_q <= LOCK_T;
    end else if (tick && lock_q != '0) begin
      lock_q <= lock_q - TMR_W'(1);
    end
  end

  assign enable_out = EN_ACTIVE_HIGH ? en_q : ~en_q;
  assign alert_n_out = alert_n_q;
  assign status_out = '{enable: en_q, alert_n: alert_n_q, lockout: (lock_q != '0)};

  // checks
  logic [TMR_W-1:0] en_ms_q;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_ms_q <= '0;
    end else if (!en_q) begin
      en_ms_q <= '0;
    end else if (tick) begin
      en_ms_q <= en_ms_q + TMR_W'(1);
    end
  end

  reset_en_off_a: assert property (@(posedge sys_clk_in) $rose(arst_n_in) |-> !en_q)
    else $error("enable active right after reset");
  press_starts_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_OFF && !button_n_s && lock_q == '0) |=> state_q == PBS_ON_HOLD)
    else $error("press in off state not taken");
  hold_len_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(en_q) |-> $past(tmr_q) == ON_HOLD_T)
    else $error("turn-on hold length wrong");
  blank_start_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(en_q) |-> state_q == PBS_BLANK && tmr_q == '0)
    else $error("blanking not started on enable");
  blank_ignore_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_BLANK && tmr_q != BLANK_T) |=> en_q)
    else $error("enable dropped during blanking");
  abort_drop_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_BLANK && tmr_q == BLANK_T && !release_n_s) |=> !en_q)
    else $error("power-on not aborted");
  reldb_restart_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_REL_DB && !button_n_s && !(en_q && !release_n_s)) |=> tmr_q == '0)
    else $error("release debounce not restarted");
  off_bounce_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_OFF_HOLD && release_n_s && button_n_s) |=> state_q == PBS_RUN)
    else $error("turn-off hold not reset by high button");
  alert_set_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $fell(alert_n_q) |-> state_q == PBS_DOWN && en_q)
    else $error("alert without power-down");
  kill_down_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_DOWN && !release_n_s) |=> !en_q && alert_n_q)
    else $error("release low did not end countdown");
  down_limit_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_DOWN) |-> tmr_q <= DOWN_T)
    else $error("countdown overran");
  run_release_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_RUN && !release_n_s) |=> !en_q && lock_q == LOCK_T)
    else $error("release low in run did not shut down");
  lock_block_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_OFF && lock_q != '0) |=> state_q == PBS_OFF)
    else $error("press taken during lockout");
  polarity_a: assert property (@(posedge sys_clk_in) enable_out == (EN_ACTIVE_HIGH ? en_q : !en_q))
    else $error("enable polarity wrong");
  tick_gap_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    tick |=> !tick)
    else $error("tick not a single pulse");
  hold_restart_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_ON_HOLD && button_n_s) |=> state_q == PBS_OFF && tmr_q == '0)
    else $error("turn-on hold not restarted by high button");
  abort_age_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $fell(en_q) && $past(state_q) == PBS_BLANK |-> $past(en_ms_q) == BLANK_T)
    else $error("abort not at end of blanking");
  blank_exit_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_BLANK && tmr_q == BLANK_T && release_n_s) |=> en_q && state_q == PBS_REL_DB)
    else $error("blanking end did not start release debounce");
  reldb_done_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_REL_DB && !(en_q && !release_n_s) && button_n_s && tmr_q == REL_DB_T)
    |=> state_q == ($past(en_q) ? PBS_RUN : PBS_OFF))
    else $error("release debounce end went to wrong state");
  run_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_RUN && release_n_s && !button_n_s) |=> state_q == PBS_OFF_HOLD)
    else $error("press in run state not taken");
  off_len_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $fell(alert_n_q) |-> $past(tmr_q) == OFF_HOLD_T)
    else $error("turn-off hold length wrong");
  alert_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_OFF_HOLD && release_n_s && !button_n_s && tmr_q == OFF_HOLD_T) |=> !alert_n_q)
    else $error("alert not raised after turn-off hold");
  en_down_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_DOWN) |-> en_q && !alert_n_q)
    else $error("countdown without enable and alert");
  timeout_drop_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_DOWN && tmr_q == DOWN_T) |=> !en_q && alert_n_q)
    else $error("countdown expiry did not drop enable");
  offhold_kill_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_OFF_HOLD && !release_n_s) |=> !en_q && state_q == PBS_REL_DB)
    else $error("release low in turn-off hold ignored");
  reldb_kill_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (state_q == PBS_REL_DB && en_q && !release_n_s) |=> !en_q && lock_q == LOCK_T)
    else $error("release low in release debounce ignored");
  lock_count_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (lock_q != '0 && !rel_off && tick) |=> lock_q == $past(lock_q) - TMR_W'(1))
    else $error("lockout not counting down");

  power_on_c: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) $rose(en_q));
  abort_c: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    state_q == PBS_BLANK && tmr_q == BLANK_T && !release_n_s);
  alert_c: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) $fell(alert_n_q));
  timeout_c: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    state_q == PBS_DOWN && tmr_q == DOWN_T);
  lockout_c: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $fell(en_q) && lock_q == LOCK_T);
endmodule : pbs_sequencer

// file: core/pbs_pkg.sv
package pbs_pkg;
  // design clock
  localparam int unsigned CLK_HZ = 20_000_000;
  // time base: one tick per millisecond
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICK_W = 15;
  // timer figures in milliseconds (one tick each)
  localparam int unsigned HOLD_BASE_MS = 32;
  localparam int unsigned HOLD_EXTRA_MS = 1;
  localparam int unsigned BLANK_MS = 512;
  localparam int unsigned RELEASE_DB_MS = 32;
  localparam int unsigned DOWN_MS = 1024;
  localparam int unsigned LOCKOUT_MS = 256;
  localparam int TMR_W = 16;

  typedef enum logic [6:0] {
    PBS_OFF      = 7'b000_0001,
    PBS_ON_HOLD  = 7'b000_0010,
    PBS_BLANK    = 7'b000_0100,
    PBS_REL_DB   = 7'b000_1000,
    PBS_RUN      = 7'b001_0000,
    PBS_OFF_HOLD = 7'b010_0000,
    PBS_DOWN     = 7'b100_0000
  } pbs_state_e;

  // status bundle seen by the outside
  typedef struct packed {
    logic enable;
    logic alert_n;
    logic lockout;
  } pbs_status_s;
endpackage : pbs_pkg

// file: core/pbs_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pins
module pbs_sync
  import pbs_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic sys_clk_in, // design clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic async_in, // raw pin level
  output logic sync_out // synchronised level
);
  logic meta_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pbs_sync

// file: dv/pbs_partner.sv
`timescale 1ns/1ps
// processor beside the sequencer: raises release after power-up, drops it on request
module pbs_partner (
  input wire logic sys_clk_in, // design clock
  input wire logic en_in, // converter enable, active high
  input wire logic alert_n_in, // shutdown alert, active low
  input wire logic kill_in, // bench asks for power-off
  input wire logic [31:0] up_in, // cycles to raise release after power-up
  input wire logic [31:0] dn_in, // cycles from alert to release low, 0 = never
  output logic release_n_out // power release, active low
);
  int up_q;
  int dn_q;
  initial release_n_out = 1'b0;
  always @(negedge sys_clk_in) begin
    up_q <= en_in ? up_q + 1 : 0;
    dn_q <= (en_in && !alert_n_in) ? dn_q + 1 : 0;
    // unpowered processor holds release low
    if (!en_in) begin
      release_n_out <= 1'b0;
    end else if (kill_in) begin
      release_n_out <= 1'b0;
    end else if (dn_in != 0 && dn_q >= int'(dn_in)) begin
      release_n_out <= 1'b0;
    end else if (up_q >= int'(up_in)) begin
      release_n_out <= 1'b1;
    end
  end
endmodule : pbs_partner

// file: dv/tb_pushbutton_power_sequencer.sv
`timescale 1ns/1ps
module tb_pushbutton_power_sequencer
  import pbs_pkg::*;
;
  localparam int MS = 10;
  `define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h seen %0h", n, e, s); end end
  logic sys_clk_in, arst_n_in, button_n_in, release_n, kill, en1, al1, en2;
  logic [31:0] up_d, dn_d, seed;
  pbs_status_s st1;
  int err_total = 0;
  int checked = 0;
  int cyc_cnt = 0;
  int waited, t0;

  pbs_sequencer #(.TICK_CYC(MS)) dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .button_n_in(button_n_in), .release_n_in(release_n), .enable_out(en1), .alert_n_out(al1),
    .status_out(st1));
  pbs_sequencer #(.TICK_CYC(MS), .ON_TIME_EXTEND_MS(5), .EN_ACTIVE_HIGH(1'b0)) dut2 (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .button_n_in(button_n_in),
    .release_n_in(release_n), .enable_out(en2), .alert_n_out(), .status_out());
  pbs_partner u_cpu (.sys_clk_in(sys_clk_in), .en_in(en1), .alert_n_in(al1), .kill_in(kill),
    .up_in(up_d), .dn_in(dn_d), .release_n_out(release_n));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) cyc_cnt <= cyc_cnt + 1;

  function automatic int rnd(input int n);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[15:0]) % n;
  endfunction : rnd

  function automatic logic sel(input int w);
    return (w == 0) ? en1 : (w == 1) ? al1 : st1.lockout;
  endfunction : sel

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wait_for(input int w, input logic v, input int lim);
    waited = 0;
    while (sel(w) !== v && waited < lim) begin
      cyc(1);
      waited++;
    end
    if (sel(w) !== v) begin
      err_total++;
      $display("[ERR] wait %0d exp %0b seen %0b", w, v, sel(w));
      wrap_up();
    end
  endtask : wait_for

  // press through blanking, bounce inside the release debounce, then run
  task automatic power_on();
    up_d = (50 + rnd(300)) * MS;
    button_n_in = 1'b0;
    wait_for(0, 1'b1, 40 * MS);
    cyc(522 * MS);
    `CHK("enable", 1'b1, en1);
    `CHK("alert_n", 1'b1, al1);
    button_n_in = 1'b1;
    cyc(20 * MS);
    button_n_in = 1'b0;
    cyc(35 * MS);
    `CHK("alert_n", 1'b1, al1);
    button_n_in = 1'b1;
    cyc(40 * MS);
    `CHK("enable_low_true", ~en1, en2);
  endtask : power_on

  initial begin
    #5_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    arst_n_in = 1'b0;
    button_n_in = 1'b1;
    kill = 1'b0;
    up_d = 32'h4000_0000;
    dn_d = 32'h0000_0000;
    seed = 32'h7710_1d4a;
    cyc(16);
    arst_n_in = 1'b1;
    cyc(2);
    `CHK("enable", 1'b0, en1);
    `CHK("alert_n", 1'b1, al1);
    `CHK("lockout", 1'b0, st1.lockout);
    `CHK("enable_low_true", 1'b1, en2);
    done("reset");
    for (int i = 0; i < 3; i++) begin
      button_n_in = 1'b0;
      cyc((5 + rnd(20)) * MS);
      button_n_in = 1'b1;
      cyc(MS);
    end
    `CHK("enable", 1'b0, en1);
    button_n_in = 1'b0;
    cyc(31 * MS);
    `CHK("enable", 1'b0, en1);
    wait_for(0, 1'b1, 3 * MS);
    `CHK("enable_ext", 1'b1, en2);
    cyc(7 * MS);
    `CHK("enable_ext", 1'b0, en2);
    cyc(493 * MS);
    button_n_in = 1'b1;
    cyc(10 * MS);
    `CHK("enable", 1'b1, en1);
    `CHK("alert_n", 1'b1, al1);
    wait_for(0, 1'b0, 4 * MS);
    `CHK("lockout", 1'b0, st1.lockout);
    cyc(45 * MS);
    done("abort");
    power_on();
    dn_d = (20 + rnd(100)) * MS;
    button_n_in = 1'b0;
    cyc(31 * MS);
    `CHK("alert_n", 1'b1, al1);
    wait_for(1, 1'b0, 3 * MS);
    button_n_in = 1'b1;
    `CHK("enable", 1'b1, en1);
    wait_for(0, 1'b0, dn_d + 8);
    `CHK("not_early", 1'b1, waited >= int'(dn_d));
    `CHK("alert_n", 1'b1, al1);
    `CHK("lockout", 1'b1, st1.lockout);
    t0 = cyc_cnt;
    cyc(40 * MS);
    button_n_in = 1'b0;
    cyc(100 * MS);
    button_n_in = 1'b1;
    `CHK("enable", 1'b0, en1);
    `CHK("lockout", 1'b1, st1.lockout);
    wait_for(2, 1'b0, 200 * MS);
    `CHK("lock_len", 1'b1, cyc_cnt - t0 >= 255 * MS && cyc_cnt - t0 <= 257 * MS);
    done("release_off");
    power_on();
    kill = 1'b1;
    wait_for(0, 1'b0, 6);
    `CHK("lockout", 1'b1, st1.lockout);
    kill = 1'b0;
    wait_for(2, 1'b0, 260 * MS);
    done("kill_in_run");
    dn_d = 32'h0000_0000;
    power_on();
    button_n_in = 1'b0;
    wait_for(1, 1'b0, 40 * MS);
    button_n_in = 1'b1;
    t0 = cyc_cnt;
    wait_for(0, 1'b0, 1030 * MS);
    `CHK("down_len", 1'b1, cyc_cnt - t0 >= 1023 * MS && cyc_cnt - t0 <= 1025 * MS);
    `CHK("lockout", 1'b0, st1.lockout);
    done("timeout");
    wrap_up();
  end
endmodule : tb_pushbutton_power_sequencer
